// File: verilog/lisi_pkg.sv
// package: register map, field positions, reset values and timing constants of the line status block
`default_nettype none

package lisi_pkg;

	// host port shape
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// register offsets on the parallel port
	localparam logic [7:0] REG_LINE_INFORMATION_TWO = 8'h11;
	localparam logic [7:0] REG_SR1   = 8'h16;
	localparam logic [7:0] REG_LINE_INTERRUPT_MASK_ONE  = 8'h17;
	localparam logic [7:0] REG_LINE_INTERFACE_CONTROL_FOUR  = 8'h7B;

	// reset values
	localparam logic [7:0] RST_LINE_INFORMATION_TWO = 8'h00;
	localparam logic [7:0] RST_SR1   = 8'h00;
	localparam logic [7:0] RST_LINE_INTERRUPT_MASK_ONE  = 8'h00;
	localparam logic [7:0] RST_LINE_INTERFACE_CONTROL_FOUR  = 8'h00;

	// control register four fields
	localparam int LINE_INTERFACE_CONTROL_FOUR_RT_LSB  = 0;
	localparam int LINE_INTERFACE_CONTROL_FOUR_TT_LSB  = 2;
	localparam int LINE_INTERFACE_CONTROL_FOUR_MPS_LSB = 4;
	localparam int LINE_INTERFACE_CONTROL_FOUR_MARK_INVERSION_INVERT    = 6;
	localparam int LINE_INTERFACE_CONTROL_FOUR_MARK_INVERSION_ENABLE    = 7;

	// status and mask bit positions
	localparam int ST_LOTC  = 0;
	localparam int ST_OPEN  = 1;
	localparam int ST_CLIM  = 2;
	localparam int ST_CLOSS = 3;
	localparam int ST_JITTER_BUFFER_LIMIT_EVENT  = 4;
	localparam int ST_SIGC  = 5;
	localparam int ST_TMR   = 6;
	localparam int ST_INPUT_LEVEL_LOW  = 7;
	// bits that latch on both edges of their condition
	localparam logic [7:0] DBL_MASK = 8'h8F;

	// positions in the vector of pin inputs that pass the two-stage synchroniser
	localparam int AS_LVL   = 0;
	localparam int AS_OPEN  = 4;
	localparam int AS_CLIM  = 5;
	localparam int AS_BOC   = 6;
	localparam int AS_CLOSS = 7;
	localparam int AS_JLIM  = 8;
	localparam int AS_SIGC  = 9;
	localparam int AS_LOWL  = 10;
	localparam int AS_RXC   = 11;
	localparam int AS_TXC   = 12;
	localparam int AS_PERR  = 13;
	localparam int AS_W     = 14;

	// clock and timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int LOTC_T1_NS    = 5181;
	localparam int LOTC_E1_NS    = 3906;
	localparam logic [7:0] LOTC_T1_CYC = 8'((LOTC_T1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] LOTC_E1_CYC = 8'((LOTC_E1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int INPUT_LEVEL_LOW_TIME_NS  = 50_000_000;
	localparam int T1_RATE_KHZ   = 1544;
	localparam int E1_RATE_KHZ   = 2048;
	localparam int TMR_LONG_US   = 1_000_000;
	localparam int TMR_T1_SHORT_US = 42_000;
	localparam int TMR_E1_SHORT_US = 62_500;

	// pattern synchroniser
	localparam logic [5:0] SYNC_MATCH_N = 6'd32;
	localparam logic [5:0] SYNC_WIN_LAST = 6'd63;
	localparam logic [2:0] SYNC_ERR_N = 3'd6;

	typedef enum logic {
		SYNC_HUNT = 1'b0,
		SYNC_LOCK = 1'b1
	} lisi_sync_e;

endpackage

`default_nettype wire

// File: verilog/lisi_pattern_sync.sv
// module: real-time pattern synchroniser, gains lock on matches and drops it on error density
`timescale 1ns/1ps
`default_nettype none

module lisi_pattern_sync (
	input  wire logic mclk_i,
	input  wire logic nrst_i,
	input  wire logic bit_valid_i,
	input  wire logic bit_err_i,
	output logic      sync_o
);
	import lisi_pkg::*;

	typedef struct packed {
		lisi_sync_e state;
		logic [5:0] match_cnt;
		logic [5:0] bit_cnt;
		logic [2:0] err_cnt;
	} lisi_psync_s;

	lisi_psync_s st_reg;
	lisi_psync_s st_next;
	logic [2:0]  err_sum;

	always_comb begin
		st_next = st_reg;
		err_sum = st_reg.err_cnt + {2'b00, bit_err_i};
		if (bit_valid_i) begin
			unique case (st_reg.state)
				SYNC_HUNT: begin
					if (bit_err_i) begin
						st_next.match_cnt = 6'h00;
					end else if (st_reg.match_cnt == SYNC_MATCH_N - 6'd1) begin
						st_next.state = SYNC_LOCK;
						st_next.match_cnt = 6'h00;
						st_next.bit_cnt = 6'h00;
						st_next.err_cnt = 3'h0;
					end else begin
						st_next.match_cnt = st_reg.match_cnt + 6'd1;
					end
				end
				SYNC_LOCK: begin
					if (err_sum >= SYNC_ERR_N) begin
						st_next.state = SYNC_HUNT;
						st_next.match_cnt = 6'h00;
					end else if (st_reg.bit_cnt == SYNC_WIN_LAST) begin
						st_next.bit_cnt = 6'h00;
						st_next.err_cnt = 3'h0;
					end else begin
						st_next.bit_cnt = st_reg.bit_cnt + 6'd1;
						st_next.err_cnt = err_sum;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			st_reg <= '{SYNC_HUNT, 6'h00, 6'h00, 3'h0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign sync_o = st_reg.state;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);

	a_sync_gain: assert property (st_reg.state == SYNC_HUNT && st_reg.match_cnt == 6'd31
		&& bit_valid_i && !bit_err_i |=> sync_o) else $error("sync not gained after 32 matches");
	a_sync_drop: assert property (st_reg.state == SYNC_LOCK && st_reg.err_cnt == 3'd5
		&& bit_valid_i && bit_err_i |=> !sync_o) else $error("sync kept after six errors");
	a_sync_hold: assert property (!bit_valid_i |=> $stable(sync_o))
		else $error("sync moved without a bit");
	c_sync_lock: cover property ($rose(sync_o));

endmodule // lisi_pattern_sync

`default_nettype wire

// File: verilog/lisi_status.sv
// module: line interface status, interrupt mask and control register four behind the host port
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - transmit termination code selects off/75/100/120 ohm
// - T1 prescaler codes map to master clock rates
// - E1 prescaler codes map to master clock rates
// - invert bit inverts mark-inversion signal at tips
// - real-time open-circuit flag in information register
// - real-time current-limit flag regardless of limiter enable
// - real-time code detected flag follows detector
// - pattern sync: 32 matches set, six-of-64 errors clear
// - transmit clock loss after one quiet channel time
// - latched open-circuit and current-limit double bits
// - latched carrier-loss double bit
// - jitter limit event sets, clears on read
// - signaling change event from enabled channels
// - timer event at counter update interval, receive clock
// - low input level latched after about 50 ms
// - mask bit gates source; conditions interrupt both edges
// - jitter clock source: master clock or PLL
module lisi_status #(
	parameter int TMR_T1_LONG_CNT  = lisi_pkg::TMR_LONG_US / 1000 * lisi_pkg::T1_RATE_KHZ,
	parameter int TMR_T1_SHORT_CNT = lisi_pkg::TMR_T1_SHORT_US * lisi_pkg::T1_RATE_KHZ / 1000,
	parameter int TMR_E1_LONG_CNT  = lisi_pkg::TMR_LONG_US / 1000 * lisi_pkg::E1_RATE_KHZ,
	parameter int TMR_E1_SHORT_CNT = lisi_pkg::TMR_E1_SHORT_US * lisi_pkg::E1_RATE_KHZ / 1000,
	parameter int INPUT_LEVEL_LOW_CYCLES      = lisi_pkg::INPUT_LEVEL_LOW_TIME_NS / lisi_pkg::CLK_PERIOD_NS
) (
	input  wire logic                          mclk_i,
	input  wire logic                          nrst_i,
	// host parallel port
	input  wire logic [lisi_pkg::ADDR_W-1:0]   addr_i,
	input  wire logic [lisi_pkg::DATA_W-1:0]   wdata_i,
	input  wire logic                          wr_i,
	input  wire logic                          rd_i,
	output logic      [lisi_pkg::DATA_W-1:0]   rdata_o,
	output logic                               irq_o,
	// settings held in other control registers of the device
	input  wire logic                          e1_mode_i,
	input  wire logic                          jitter_clk_source_sel_i,
	input  wire logic                          counter_update_select_i,
	// analog front end and line side, asynchronous to mclk_i
	input  wire logic [3:0]                    rx_level_i,
	input  wire logic                          tx_open_circuit_i,
	input  wire logic                          tx_current_limit_i,
	input  wire logic                          bit_oriented_code_i,
	input  wire logic                          rx_carrier_loss_i,
	input  wire logic                          jitter_limit_i,
	input  wire logic                          signaling_change_i,
	input  wire logic                          level_below_thresh_i,
	input  wire logic                          rx_clk_i,
	input  wire logic                          line_tx_clock_in_i,
	input  wire logic                          pattern_err_i,
	// controls to the analog front end
	output logic                               tx_term_75_o,
	output logic                               tx_term_100_o,
	output logic                               tx_term_120_o,
	output logic                               rx_term_75_o,
	output logic                               rx_term_100_o,
	output logic                               rx_term_120_o,
	output logic      [3:0]                    mclk_div_o,
	output logic                               mclk_e1_rate_o,
	output logic                               jitter_clk_from_pll_o,
	output logic                               mark_inversion_invert_o,
	output logic                               mark_inversion_enable_o
);
	import lisi_pkg::*;

	localparam int TMR_W  = $clog2(TMR_E1_LONG_CNT + 1);
	localparam int INPUT_LEVEL_LOW_W = $clog2(INPUT_LEVEL_LOW_CYCLES + 1);

	typedef struct packed {
		logic [AS_W-1:0]   s1;
		logic [AS_W-1:0]   s2;
		logic [AS_W-1:0]   prev;
		logic [7:0]        line_interface_control_four;
		logic [7:0]        mask;
		logic [7:0]        status;
		logic [7:0]        cond_prev;
		logic [7:0]        info;
		logic [7:0]        rdata;
		logic [7:0]        lotc_cnt;
		logic              lotc_cond;
		logic [INPUT_LEVEL_LOW_W-1:0] input_level_low_cnt;
		logic              input_level_low_cond;
		logic [TMR_W-1:0]  tmr_cnt;
		logic              irq;
		logic [2:0]        tx_term;
		logic [2:0]        rx_term;
		logic [3:0]        mclk_div;
		logic              mclk_e1;
		logic              jclk_pll;
		logic              cmi_inv;
		logic              cmi_en;
	} lisi_state_s;

	lisi_state_s      st_reg;
	lisi_state_s      st_next;
	logic [AS_W-1:0]  async_in;
	logic             pat_sync;
	logic             rxc_rise;
	logic             txc_edge;
	logic             jitter_buffer_limit_event_rise;
	logic             sigc_rise;
	logic             tmr_tick;
	logic             wr_line_interface_control_four;
	logic             wr_line_interrupt_mask_one;
	logic             rd_sr1;
	logic [7:0]       cond;
	logic [7:0]       set_bits;
	logic [7:0]       clr_bits;
	logic [7:0]       lotc_lim;
	logic [TMR_W-1:0] tmr_lim;

	assign async_in = {pattern_err_i, line_tx_clock_in_i, rx_clk_i, level_below_thresh_i,
		signaling_change_i, jitter_limit_i, rx_carrier_loss_i, bit_oriented_code_i,
		tx_current_limit_i, tx_open_circuit_i, rx_level_i};

	////////////////////////////////////////////////////////////////////////////////
	// pattern synchroniser, one bit per rising edge of the receive clock

	lisi_pattern_sync u_psync (
		.mclk_i      (mclk_i),
		.nrst_i      (nrst_i),
		.bit_valid_i (rxc_rise),
		.bit_err_i   (st_reg.s2[AS_PERR]),
		.sync_o      (pat_sync)
	);

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		st_next = st_reg;
		// two-stage synchroniser, then one stage for edge detection
		st_next.s1 = async_in;
		st_next.s2 = st_reg.s1;
		st_next.prev = st_reg.s2;

		rxc_rise  = st_reg.s2[AS_RXC] & ~st_reg.prev[AS_RXC];
		txc_edge  = st_reg.s2[AS_TXC] ^ st_reg.prev[AS_TXC];
		jitter_buffer_limit_event_rise = st_reg.s2[AS_JLIM] & ~st_reg.prev[AS_JLIM];
		sigc_rise = st_reg.s2[AS_SIGC] & ~st_reg.prev[AS_SIGC];
		wr_line_interface_control_four = wr_i && (addr_i == REG_LINE_INTERFACE_CONTROL_FOUR);
		wr_line_interrupt_mask_one = wr_i && (addr_i == REG_LINE_INTERRUPT_MASK_ONE);
		rd_sr1  = rd_i && (addr_i == REG_SR1);

		// transmit clock watchdog, limit is one channel time of the line rate
		lotc_lim = e1_mode_i ? LOTC_E1_CYC : LOTC_T1_CYC;
		if (txc_edge) begin
			st_next.lotc_cnt = 8'h00;
			st_next.lotc_cond = 1'b0;
		end else if (st_reg.lotc_cnt >= lotc_lim - 8'd1) begin
			st_next.lotc_cond = 1'b1;
		end else begin
			st_next.lotc_cnt = st_reg.lotc_cnt + 8'd1;
		end

		// low input level must persist before the condition is taken
		if (!st_reg.s2[AS_LOWL]) begin
			st_next.input_level_low_cnt = '0;
			st_next.input_level_low_cond = 1'b0;
		end else if (st_reg.input_level_low_cnt >= INPUT_LEVEL_LOW_W'(INPUT_LEVEL_LOW_CYCLES - 1)) begin
			st_next.input_level_low_cond = 1'b1;
		end else begin
			st_next.input_level_low_cnt = st_reg.input_level_low_cnt + INPUT_LEVEL_LOW_W'(1);
		end

		// update interval counted in receive clock periods
		if (e1_mode_i) begin
			tmr_lim = counter_update_select_i ? TMR_W'(TMR_E1_SHORT_CNT - 1)
				: TMR_W'(TMR_E1_LONG_CNT - 1);
		end else begin
			tmr_lim = counter_update_select_i ? TMR_W'(TMR_T1_SHORT_CNT - 1)
				: TMR_W'(TMR_T1_LONG_CNT - 1);
		end
		tmr_tick = 1'b0;
		if (rxc_rise) begin
			if (st_reg.tmr_cnt >= tmr_lim) begin
				st_next.tmr_cnt = '0;
				tmr_tick = 1'b1;
			end else begin
				st_next.tmr_cnt = st_reg.tmr_cnt + TMR_W'(1);
			end
		end

		// conditions of the double interrupt bits
		cond = 8'h00;
		cond[ST_LOTC]  = st_reg.lotc_cond;
		cond[ST_OPEN]  = st_reg.s2[AS_OPEN];
		cond[ST_CLIM]  = st_reg.s2[AS_CLIM];
		cond[ST_CLOSS] = st_reg.s2[AS_CLOSS];
		cond[ST_INPUT_LEVEL_LOW]  = st_reg.input_level_low_cond;
		st_next.cond_prev = cond;

		set_bits = (cond ^ st_reg.cond_prev) & DBL_MASK;
		set_bits[ST_JITTER_BUFFER_LIMIT_EVENT] = jitter_buffer_limit_event_rise;
		set_bits[ST_SIGC] = sigc_rise;
		set_bits[ST_TMR]  = tmr_tick;

		// a read clears what it returned; a new event in the same cycle survives
		clr_bits = rd_sr1 ? st_reg.status : 8'h00;
		st_next.status = (st_reg.status & ~clr_bits) | set_bits;

		// real-time information register
		st_next.info = {pat_sync, st_reg.s2[AS_BOC], st_reg.s2[AS_CLIM],
			st_reg.s2[AS_OPEN], st_reg.s2[AS_LVL+3:AS_LVL]};

		// host writes
		if (wr_line_interface_control_four) begin
			st_next.line_interface_control_four = wdata_i;
		end
		if (wr_line_interrupt_mask_one) begin
			st_next.mask = wdata_i;
		end

		// host reads, answered one cycle later; unmapped offsets read zero
		st_next.rdata = 8'h00;
		if (rd_i) begin
			unique case (addr_i)
				REG_LINE_INFORMATION_TWO: st_next.rdata = st_reg.info;
				REG_SR1:   st_next.rdata = st_reg.status;
				REG_LINE_INTERRUPT_MASK_ONE:  st_next.rdata = st_reg.mask;
				REG_LINE_INTERFACE_CONTROL_FOUR:  st_next.rdata = st_reg.line_interface_control_four;
				default:   st_next.rdata = 8'h00;
			endcase
		end

		st_next.irq = |(st_next.status & st_next.mask);

		// termination decode
		unique case (st_next.line_interface_control_four[LINE_INTERFACE_CONTROL_FOUR_TT_LSB +: 2])
			2'b00: st_next.tx_term = 3'b000;
			2'b01: st_next.tx_term = 3'b001;
			2'b10: st_next.tx_term = 3'b010;
			2'b11: st_next.tx_term = 3'b100;
		endcase
		unique case (st_next.line_interface_control_four[LINE_INTERFACE_CONTROL_FOUR_RT_LSB +: 2])
			2'b00: st_next.rx_term = 3'b000;
			2'b01: st_next.rx_term = 3'b001;
			2'b10: st_next.rx_term = 3'b010;
			2'b11: st_next.rx_term = 3'b100;
		endcase

		// master clock is the base rate times 1, 2, 4 or 8; the PLL path needs E1 base rate
		st_next.mclk_div = 4'h1 << st_next.line_interface_control_four[LINE_INTERFACE_CONTROL_FOUR_MPS_LSB +: 2];
		st_next.mclk_e1 = e1_mode_i | jitter_clk_source_sel_i;
		st_next.jclk_pll = jitter_clk_source_sel_i;
		st_next.cmi_inv = st_next.line_interface_control_four[LINE_INTERFACE_CONTROL_FOUR_MARK_INVERSION_INVERT];
		st_next.cmi_en = st_next.line_interface_control_four[LINE_INTERFACE_CONTROL_FOUR_MARK_INVERSION_ENABLE];
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			st_reg <= '0;
			st_reg.line_interface_control_four <= RST_LINE_INTERFACE_CONTROL_FOUR;
			st_reg.mask <= RST_LINE_INTERRUPT_MASK_ONE;
			st_reg.status <= RST_SR1;
			st_reg.info <= RST_LINE_INFORMATION_TWO;
			st_reg.mclk_div <= 4'h1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdata_o                 = st_reg.rdata;
	assign irq_o                   = st_reg.irq;
	assign tx_term_75_o            = st_reg.tx_term[0];
	assign tx_term_100_o           = st_reg.tx_term[1];
	assign tx_term_120_o           = st_reg.tx_term[2];
	assign rx_term_75_o            = st_reg.rx_term[0];
	assign rx_term_100_o           = st_reg.rx_term[1];
	assign rx_term_120_o           = st_reg.rx_term[2];
	assign mclk_div_o              = st_reg.mclk_div;
	assign mclk_e1_rate_o          = st_reg.mclk_e1;
	assign jitter_clk_from_pll_o   = st_reg.jclk_pll;
	assign mark_inversion_invert_o = st_reg.cmi_inv;
	assign mark_inversion_enable_o = st_reg.cmi_en;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);

	a_term_select: assert property (wr_line_interface_control_four && wdata_i[3:2] == 2'b10
		|=> tx_term_100_o && !tx_term_75_o && !tx_term_120_o
		##1 (tx_term_100_o || $past(wr_line_interface_control_four)))
		else $error("transmit termination not 100 ohm after write");
	a_prescale_code: assert property (wr_line_interface_control_four
		|=> mclk_div_o == (4'h1 << $past(wdata_i[5:4]))) else $error("prescale mismatch");
	a_prescale_e1: assert property (e1_mode_i |=> mclk_e1_rate_o)
		else $error("E1 mode without E1 base rate");
	a_cmi_invert: assert property (wr_line_interface_control_four |=> mark_inversion_invert_o == $past(wdata_i[6]))
		else $error("invert control not taken");
	a_cmi_enable: assert property (wr_line_interface_control_four |=> mark_inversion_enable_o == $past(wdata_i[7]))
		else $error("enable control not taken");
	a_level_read: assert property (rd_i && addr_i == REG_LINE_INFORMATION_TWO
		|=> rdata_o[3:0] == $past(st_reg.s2[AS_LVL+3:AS_LVL], 2)) else $error("level mismatch");
	a_open_rt: assert property ($rose(st_reg.s2[AS_OPEN]) |=> st_reg.info[4]
		&& st_reg.status[ST_OPEN]) else $error("open circuit not reported");
	a_climit_rt: assert property ($fell(st_reg.s2[AS_CLIM]) |=> !st_reg.info[5]
		&& st_reg.status[ST_CLIM]) else $error("current limit edge not latched");
	a_txclk_loss: assert property (!txc_edge && st_reg.lotc_cnt >= lotc_lim - 8'd1
		&& !st_reg.lotc_cond |=> ##1 st_reg.status[ST_LOTC]) else $error("clock loss missed");
	a_jitter_buffer_limit_event_clear: assert property (rd_sr1 && st_reg.status[ST_JITTER_BUFFER_LIMIT_EVENT] && !jitter_buffer_limit_event_rise
		|=> !st_reg.status[ST_JITTER_BUFFER_LIMIT_EVENT]) else $error("limit event not cleared by read");
	a_event_wins: assert property (rd_sr1 && sigc_rise |=> st_reg.status[ST_SIGC])
		else $error("event lost under read clear");
	a_mask_block: assert property (st_reg.mask == 8'h00 && !wr_line_interrupt_mask_one |=> !irq_o)
		else $error("interrupt with all sources masked");
	a_irq_pending: assert property (st_reg.status[ST_CLOSS] && st_reg.mask[ST_CLOSS]
		&& !rd_sr1 && !wr_line_interrupt_mask_one |=> irq_o) else $error("masked pending bit gives no interrupt");
	a_code_rt: assert property ($changed(st_reg.s2[AS_BOC])
		|=> st_reg.info[6] == $past(st_reg.s2[AS_BOC])) else $error("code detected flag stale");
	a_carrier_latch: assert property ($changed(st_reg.s2[AS_CLOSS])
		|=> st_reg.status[ST_CLOSS]) else $error("carrier loss edge not latched");
	a_txc_restart: assert property (txc_edge |=> !st_reg.lotc_cond)
		else $error("clock loss kept after a clock edge");
	a_timer_latch: assert property (tmr_tick |=> st_reg.status[ST_TMR])
		else $error("timer tick not latched");
	a_input_level_low_persist: assert property ($rose(st_reg.input_level_low_cond)
		|-> st_reg.input_level_low_cnt == INPUT_LEVEL_LOW_W'(INPUT_LEVEL_LOW_CYCLES - 1)) else $error("low level taken too early");
	a_jclk_source: assert property (1'b1 |=> jitter_clk_from_pll_o == $past(jitter_clk_source_sel_i))
		else $error("jitter clock source not followed");
	a_status_read: assert property (rd_sr1 |=> rdata_o == $past(st_reg.status))
		else $error("status read returned wrong value");
	a_irq_level: assert property (irq_o == |(st_reg.status & st_reg.mask))
		else $error("interrupt does not match masked pending bits");
	c_read_clear: cover property (rd_sr1 && st_reg.status != 8'h00);
	c_irq: cover property ($rose(irq_o));
	c_lotc: cover property ($rose(st_reg.lotc_cond));
	c_timer: cover property (tmr_tick);

endmodule // lisi_status

`default_nettype wire

// File: tb/lisi_host_model.sv
// host model: parallel-port master that issues register reads and writes
`timescale 1ns/1ps
`default_nettype none

module lisi_host_model (
	input  wire logic       mclk_i,
	output logic      [7:0] addr_o,
	output logic      [7:0] wdata_o,
	output logic            wr_o,
	output logic            rd_o,
	input  wire logic [7:0] rdata_i
);

	initial begin
		addr_o = 8'h00;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// one-cycle write strobe, address and data held until the sampling edge
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge mclk_i);
		wr_o <= 1'b0;
		// released lines do not keep their last value
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask

	// one-cycle read strobe, data taken 1 ns after the sampling edge
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge mclk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		#1;
		d = rdata_i;
	endtask

endmodule // lisi_host_model

`default_nettype wire

// File: tb/tb_line_interface_status_irq.sv
// testbench: register access, control fields, status latching and interrupt of the status block
`timescale 1ns/1ps
`default_nettype none

`define CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
	$display("BAD time=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module tb_line_interface_status_irq;
	import lisi_pkg::*;

	logic       mclk_i, nrst_i, e1_mode, jsel, cus, opn, clim, bit_oriented_code, closs, jlim, sigc;
	logic       lowl, rx_clk, txc, perr, irq, tx_run, rx_run;
	logic [3:0] level, div;
	logic [7:0] addr, wdata, rdata, v;
	logic       wr, rd, t75, t100, t120, r75, r100, r120, e1_rate, pll, inv, ena;
	logic [2:0] tick;
	int         n_errors = 0;
	int         checks_done = 0;

	lisi_host_model host (.mclk_i(mclk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
		.rd_o(rd), .rdata_i(rdata));

	lisi_status #(.TMR_T1_LONG_CNT(20), .TMR_T1_SHORT_CNT(10), .TMR_E1_LONG_CNT(24),
		.TMR_E1_SHORT_CNT(12), .INPUT_LEVEL_LOW_CYCLES(50)) dut (
		.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
		.rd_i(rd), .rdata_o(rdata), .irq_o(irq), .e1_mode_i(e1_mode),
		.jitter_clk_source_sel_i(jsel), .counter_update_select_i(cus), .rx_level_i(level),
		.tx_open_circuit_i(opn), .tx_current_limit_i(clim), .bit_oriented_code_i(bit_oriented_code),
		.rx_carrier_loss_i(closs), .jitter_limit_i(jlim), .signaling_change_i(sigc),
		.level_below_thresh_i(lowl), .rx_clk_i(rx_clk), .line_tx_clock_in_i(txc),
		.pattern_err_i(perr), .tx_term_75_o(t75), .tx_term_100_o(t100),
		.tx_term_120_o(t120), .rx_term_75_o(r75), .rx_term_100_o(r100),
		.rx_term_120_o(r120), .mclk_div_o(div), .mclk_e1_rate_o(e1_rate),
		.jitter_clk_from_pll_o(pll), .mark_inversion_invert_o(inv),
		.mark_inversion_enable_o(ena));

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end

	// transmit clock toggles every 8 cycles, receive clock every 4
	always @(posedge mclk_i) begin
		tick <= tick + 3'h1;
		if (tx_run && tick == 3'h7) txc <= ~txc;
		if (rx_run && tick[1:0] == 2'h3) rx_clk <= ~rx_clk;
	end

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host.read_reg(a, d);
		`CHECK(d, exp)
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge mclk_i);
	endtask

	task automatic wrap_up();
		$display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		wait_n(20000);
		n_errors++;
		wrap_up();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{nrst_i, e1_mode, jsel, cus, opn, clim, bit_oriented_code, closs, jlim, sigc} = 10'h000;
		{lowl, rx_clk, txc, perr, rx_run} = 5'h00;
		level = 4'h0;
		tick = 3'h0;
		tx_run = 1'b1;
		wait_n(5);
		nrst_i <= 1'b1;
		// reset values
		rd_chk(REG_LINE_INFORMATION_TWO, RST_LINE_INFORMATION_TWO);
		rd_chk(REG_SR1, RST_SR1);
		rd_chk(REG_LINE_INTERRUPT_MASK_ONE, RST_LINE_INTERRUPT_MASK_ONE);
		rd_chk(REG_LINE_INTERFACE_CONTROL_FOUR, RST_LINE_INTERFACE_CONTROL_FOUR);
		`CHECK(div, 4'h1)
		`CHECK(irq, 1'b0)
		// every code of every control field
		for (int i = 0; i < 4; i++) begin
			v = {2'(i), 2'(i), 2'(i), 2'(i)};
			@(posedge mclk_i);
			e1_mode <= 1'(i % 2);
			jsel <= 1'(i / 2);
			host.write_reg(REG_LINE_INTERFACE_CONTROL_FOUR, v);
			rd_chk(REG_LINE_INTERFACE_CONTROL_FOUR, v);
			`CHECK({t120, t100, t75}, (i == 0) ? 3'h0 : 3'(1 << (i - 1)))
			`CHECK({r120, r100, r75}, (i == 0) ? 3'h0 : 3'(1 << (i - 1)))
			`CHECK(div, 4'(1 << i))
			`CHECK(e1_rate, 1'(i != 0))
			`CHECK(pll, 1'(i / 2))
			`CHECK(inv, 1'(i % 2))
			`CHECK(ena, 1'(i / 2))
		end
		// writes to read-only and unmapped places are ignored
		host.write_reg(REG_LINE_INFORMATION_TWO, 8'hFF);
		host.write_reg(REG_SR1, 8'hFF);
		host.write_reg(8'h20, 8'hFF);
		rd_chk(REG_LINE_INFORMATION_TWO, 8'h00);
		rd_chk(REG_SR1, 8'h00);
		rd_chk(8'h20, 8'h00);
		// real-time flags and condition bits on both edges
		@(posedge mclk_i);
		{opn, clim, bit_oriented_code} <= 3'h7;
		level <= 4'hA;
		wait_n(8);
		rd_chk(REG_LINE_INFORMATION_TWO, 8'h7A);
		rd_chk(REG_SR1, 8'h06);
		rd_chk(REG_SR1, 8'h00);
		host.write_reg(REG_LINE_INTERRUPT_MASK_ONE, 8'h0A);
		rd_chk(REG_LINE_INTERRUPT_MASK_ONE, 8'h0A);
		`CHECK(irq, 1'b0)
		@(posedge mclk_i);
		{opn, clim, bit_oriented_code} <= 3'h0;
		level <= 4'h0;
		wait_n(8);
		`CHECK(irq, 1'b1)
		rd_chk(REG_SR1, 8'h06);
		`CHECK(irq, 1'b0)
		// carrier loss condition and the two rising-edge events
		@(posedge mclk_i);
		{closs, jlim, sigc} <= 3'h7;
		wait_n(8);
		`CHECK(irq, 1'b1)
		rd_chk(REG_SR1, 8'h38);
		@(posedge mclk_i);
		{closs, jlim, sigc} <= 3'h0;
		wait_n(8);
		`CHECK(irq, 1'b1)
		rd_chk(REG_SR1, 8'h08);
		// low input level must persist before it latches
		@(posedge mclk_i);
		lowl <= 1'b1;
		wait_n(30);
		rd_chk(REG_SR1, 8'h00);
		wait_n(40);
		rd_chk(REG_SR1, 8'h80);
		// transmit clock stops, then restarts
		@(posedge mclk_i);
		e1_mode <= 1'b0;
		tx_run <= 1'b0;
		wait_n(100);
		rd_chk(REG_SR1, 8'h00);
		wait_n(150);
		rd_chk(REG_SR1, 8'h01);
		@(posedge mclk_i);
		tx_run <= 1'b1;
		wait_n(30);
		rd_chk(REG_SR1, 8'h01);
		// receive clock runs: pattern lock, timer ticks, lock lost on errors
		@(posedge mclk_i);
		cus <= 1'b1;
		rx_run <= 1'b1;
		wait_n(200);
		rd_chk(REG_LINE_INFORMATION_TWO, 8'h00);
		wait_n(100);
		rd_chk(REG_LINE_INFORMATION_TWO, 8'h80);
		rd_chk(REG_SR1, 8'h40);
		@(posedge mclk_i);
		perr <= 1'b1;
		wait_n(80);
		rd_chk(REG_LINE_INFORMATION_TWO, 8'h00);
		host.write_reg(REG_LINE_INTERRUPT_MASK_ONE, 8'h40);
		wait_n(100);
		`CHECK(irq, 1'b1)
		wrap_up();
	end

endmodule // tb_line_interface_status_irq

`default_nettype wire
